// [verilog/lbcr_pkg.sv]
// Purpose: Shared constants and types for the bus collision recovery transmitter.
// Assumes: 50 MHz sys_clk; times held in ns and turned into cycle counts here.
// Notes: Minimum times round up to whole cycles, maximum times round down.
package lbcr_pkg;
   localparam int CNT_W = 20;
   localparam int CLK_NS = 20;
   localparam int FRAME_W = 16;
   localparam int PRIO_W = 3;
   localparam int FIFO_DEPTH = 16;
   localparam int STOP_HALVES = 4;
   localparam int SAMPLE_CYC = 8;

   typedef logic [CNT_W-1:0] lbcr_cnt_t;

   function automatic lbcr_cnt_t lbcr_cyc_min(input int ns);
      return lbcr_cnt_t'((ns + CLK_NS - 1) / CLK_NS);
   endfunction

   function automatic lbcr_cnt_t lbcr_cyc_max(input int ns);
      return lbcr_cnt_t'(ns / CLK_NS);
   endfunction

   // Level width windows
   localparam int T_HALF_NS = 416667;
   localparam int T_DEST_LO_NS = 100000;
   localparam int T_DEST1_HI_NS = 356700;
   localparam int T_VALID_LO_NS = 400000;
   localparam int T_VALID1_HI_NS = 433300;
   localparam int T_TO1_NS = 476700;
   localparam int T_DEST2_HI_NS = 723300;
   localparam int T_VALID2_LO_NS = 800000;
   localparam int T_VALID2_HI_NS = 866700;
   localparam int T_TO2_NS = 943300;
   // Recovery timing, minimum of each window is used
   localparam int T_BREAK_NS = 1200000;
   localparam int T_RECOVER_NS = 4000000;
   localparam int T_SETTLE1_NS = 12700000;
   localparam int T_SETTLE2_NS = 14000000;
   localparam int T_SETTLE3_NS = 15300000;
   localparam int T_SETTLE4_NS = 16700000;
   localparam int T_SETTLE5_NS = 18300000;

   localparam lbcr_cnt_t C_HALF = lbcr_cyc_max(T_HALF_NS);
   localparam lbcr_cnt_t C_DEST_LO = lbcr_cyc_min(T_DEST_LO_NS);
   localparam lbcr_cnt_t C_DEST1_HI = lbcr_cyc_max(T_DEST1_HI_NS);
   localparam lbcr_cnt_t C_VALID_LO = lbcr_cyc_min(T_VALID_LO_NS);
   localparam lbcr_cnt_t C_VALID1_HI = lbcr_cyc_max(T_VALID1_HI_NS);
   localparam lbcr_cnt_t C_TO1 = lbcr_cyc_min(T_TO1_NS);
   localparam lbcr_cnt_t C_DEST2_HI = lbcr_cyc_max(T_DEST2_HI_NS);
   localparam lbcr_cnt_t C_VALID2_LO = lbcr_cyc_min(T_VALID2_LO_NS);
   localparam lbcr_cnt_t C_VALID2_HI = lbcr_cyc_max(T_VALID2_HI_NS);
   localparam lbcr_cnt_t C_TO2 = lbcr_cyc_min(T_TO2_NS);
   localparam lbcr_cnt_t C_BREAK = lbcr_cyc_min(T_BREAK_NS);
   localparam lbcr_cnt_t C_RECOVER = lbcr_cyc_min(T_RECOVER_NS);
   localparam lbcr_cnt_t C_SETTLE1 = lbcr_cyc_min(T_SETTLE1_NS);
   localparam lbcr_cnt_t C_SETTLE2 = lbcr_cyc_min(T_SETTLE2_NS);
   localparam lbcr_cnt_t C_SETTLE3 = lbcr_cyc_min(T_SETTLE3_NS);
   localparam lbcr_cnt_t C_SETTLE4 = lbcr_cyc_min(T_SETTLE4_NS);
   localparam lbcr_cnt_t C_SETTLE5 = lbcr_cyc_min(T_SETTLE5_NS);
   localparam lbcr_cnt_t C_SAMPLE = lbcr_cnt_t'(SAMPLE_CYC);

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SEND = 3'h1,
      ST_BREAK = 3'h2,
      ST_SAMPLE = 3'h3,
      ST_WAIT = 3'h4
   } lbcr_state_t;

   typedef enum logic [1:0] {
      WC_GREY = 2'h0,
      WC_HALF = 2'h1,
      WC_TWO = 2'h2,
      WC_DESTROY = 2'h3
   } lbcr_wclass_t;
endpackage

// [verilog/lbcr_fifo.sv]
// Purpose: Frame queue between the user and the transmitter.
// Assumes: One clock, synchronous active-high reset.
// Notes: Read data comes straight from the storage flops.
`timescale 1ns/1ps
module lbcr_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input logic sys_clk,
   input logic rst,
   // Fill side
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      return (p == LAST) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (count != FULL);
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= next_ptr(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= next_ptr(rd_ptr);
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// [verilog/lbcr_top.sv]
// Purpose: Multi-master forward frame transmitter with collision detection and recovery.
// Assumes: bus_rx is the bus level (1 = idle high); bus_pull_low high drives the bus low.
// Notes: Each retry resends the held frame; a new frame is taken only once it has gone out.
// How it works
// [RULE1] Each bit goes out as a low and a high half of opposite level, checked per half.
// [RULE2] Levels starting at a bit edge use the first window set, mid-bit ones the second.
// [RULE3] Widths 100 to 356.7 us are a collision, 400 to 433.3 us a good half, gaps grey.
// [RULE4] In the first set a low level lasting 476.7 us is a timeout; high never times out.
// [RULE5] The second set adds 476.7-723.3 us collision, 800-866.7 us two halves, 943.3 us low.
// [RULE6] Checking runs only while this end sends its own forward frame, never on replies.
// [RULE7] A collision drops the current transfer and the same frame is sent again later.
// [RULE8] After a collision the bus is held low for a break between 1.2 ms and 14.0 ms.
// [RULE9] A high bus after the break means resolved, and resend follows 4.0 to 4.6 ms later.
// [RULE10] A low bus after the break means ongoing, and resend follows the settling wait.
// [RULE11] The settling wait is chosen from five windows by the frame priority one to five.
// [RULE12] Detection and recovery only act when multi-master mode is switched on.
// [RULE13] Only forward frames are sent; 24bit event messages are not handled.
// [RULE14] A width timer measures each synced bus level and a second timer catches timeouts.
// [RULE15] A collision flag is raised on each detected collision and cleared at resend start.
`timescale 1ns/1ps
module lbcr_top #(
   parameter int FRAME_W = lbcr_pkg::FRAME_W,
   parameter int FIFO_DEPTH = lbcr_pkg::FIFO_DEPTH,
   parameter lbcr_pkg::lbcr_cnt_t HALF_CYC = lbcr_pkg::C_HALF,
   parameter lbcr_pkg::lbcr_cnt_t DEST_LO = lbcr_pkg::C_DEST_LO,
   parameter lbcr_pkg::lbcr_cnt_t DEST1_HI = lbcr_pkg::C_DEST1_HI,
   parameter lbcr_pkg::lbcr_cnt_t VALID_LO = lbcr_pkg::C_VALID_LO,
   parameter lbcr_pkg::lbcr_cnt_t VALID1_HI = lbcr_pkg::C_VALID1_HI,
   parameter lbcr_pkg::lbcr_cnt_t TO1_CYC = lbcr_pkg::C_TO1,
   parameter lbcr_pkg::lbcr_cnt_t DEST2_HI = lbcr_pkg::C_DEST2_HI,
   parameter lbcr_pkg::lbcr_cnt_t VALID2_LO = lbcr_pkg::C_VALID2_LO,
   parameter lbcr_pkg::lbcr_cnt_t VALID2_HI = lbcr_pkg::C_VALID2_HI,
   parameter lbcr_pkg::lbcr_cnt_t TO2_CYC = lbcr_pkg::C_TO2,
   parameter lbcr_pkg::lbcr_cnt_t BREAK_CYC = lbcr_pkg::C_BREAK,
   parameter lbcr_pkg::lbcr_cnt_t RECOVER_CYC = lbcr_pkg::C_RECOVER,
   parameter lbcr_pkg::lbcr_cnt_t SETTLE1_CYC = lbcr_pkg::C_SETTLE1,
   parameter lbcr_pkg::lbcr_cnt_t SETTLE2_CYC = lbcr_pkg::C_SETTLE2,
   parameter lbcr_pkg::lbcr_cnt_t SETTLE3_CYC = lbcr_pkg::C_SETTLE3,
   parameter lbcr_pkg::lbcr_cnt_t SETTLE4_CYC = lbcr_pkg::C_SETTLE4,
   parameter lbcr_pkg::lbcr_cnt_t SETTLE5_CYC = lbcr_pkg::C_SETTLE5
) (
   // Clock and reset
   input logic sys_clk,
   input logic rst,
   // Mode
   input logic mm_enable,
   // Frame input
   input logic frame_valid,
   output logic frame_ready,
   input logic [FRAME_W-1:0] frame_data,
   input logic [lbcr_pkg::PRIO_W-1:0] frame_prio,
   // Bus pins
   input logic bus_rx,
   output logic bus_pull_low,
   // Status
   output logic busy,
   output logic tx_done,
   output logic coll_flag,
   output logic xfer_abort,
   output lbcr_pkg::lbcr_wclass_t width_class
);
   import lbcr_pkg::*;

   localparam int HALVES = 2 * (1 + FRAME_W) + STOP_HALVES;
   localparam int HW = $clog2(HALVES + 1);
   localparam logic [HW-1:0] LAST_HALF = HW'(HALVES - 1);
   localparam logic [HW-1:0] DATA_HALVES = HW'(2 * (1 + FRAME_W));
   localparam int QW = FRAME_W + PRIO_W;

   lbcr_state_t state;
   logic q_valid;
   logic q_ready;
   logic [QW-1:0] q_data;
   logic [FRAME_W-1:0] cur_frame;
   logic [PRIO_W-1:0] cur_prio;
   logic [HW-1:0] hidx;
   lbcr_cnt_t hc;
   lbcr_cnt_t tcnt;
   lbcr_cnt_t wtgt;
   logic rx_s1;
   logic rx_s2;
   logic rx_s3;
   logic rx_lvl;
   logic rx_edge;
   lbcr_cnt_t wid;
   lbcr_cnt_t tmo_cnt;
   logic pat2_q;
   logic half_tick;
   logic coll_hit;
   logic retx_start;

   // Frames wait here so the user is not stalled by a retry sequence until the queue is full
   lbcr_fifo #(
      .WIDTH(QW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(frame_valid),
      .in_ready(frame_ready),
      .in_data({frame_prio, frame_data}),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_data)
   );

   // Start bit is a one; data follows MSB first; ones go low then high
   function automatic logic half_level(input logic [HW-1:0] idx, input logic [FRAME_W-1:0] fr);
      int n;
      logic b;
      n = int'(idx[HW-1:1]);
      b = 1'b1;
      if (idx >= DATA_HALVES) begin
         return 1'b1;
      end
      if (n != 0) begin
         b = fr[FRAME_W-n];
      end
      return idx[0] ? b : ~b; // [RULE1]
   endfunction

   function automatic lbcr_wclass_t wclass(input lbcr_cnt_t w, input logic p2);
      if (w >= DEST_LO && w <= DEST1_HI) begin
         return WC_DESTROY; // [RULE3]
      end else if (w >= VALID_LO && w <= VALID1_HI) begin
         return WC_HALF; // [RULE3]
      end else if (p2 && w >= TO1_CYC && w <= DEST2_HI) begin
         return WC_DESTROY; // [RULE5]
      end else if (p2 && w >= VALID2_LO && w <= VALID2_HI) begin
         return WC_TWO; // [RULE5]
      end
      return WC_GREY;
   endfunction

   // Out-of-range priority takes the longest wait so it never beats a valid one
   function automatic lbcr_cnt_t settle(input logic [PRIO_W-1:0] p);
      case (p)
         3'h1: return SETTLE1_CYC;
         3'h2: return SETTLE2_CYC;
         3'h3: return SETTLE3_CYC;
         3'h4: return SETTLE4_CYC;
         default: return SETTLE5_CYC; // [RULE11]
      endcase
   endfunction

   assign q_ready = (state == ST_IDLE);
   assign busy = (state != ST_IDLE);
   assign half_tick = (state == ST_SEND) && (hc == HALF_CYC - 1'b1);
   assign retx_start = (state == ST_WAIT) && (tcnt == wtgt - 1'b1);
   assign rx_edge = (rx_s2 == rx_s3) && (rx_s2 != rx_lvl);

   // Only own forward frames are judged, and only in multi-master mode
   assign coll_hit = mm_enable && (state == ST_SEND) && // [RULE6] [RULE12]
      ((rx_edge && wclass(wid, pat2_q) == WC_DESTROY) || // [RULE2]
       (!rx_lvl && tmo_cnt >= (pat2_q ? TO2_CYC : TO1_CYC))); // [RULE4] [RULE5]

   // Receive line synchroniser; a change counts once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
         rx_lvl <= 1'b1;
      end else begin
         rx_s1 <= bus_rx;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) begin
            rx_lvl <= rx_s2;
         end
      end
   end

   // Width timer restarts at each edge; timeout timer only runs on a low level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wid <= '0;
         tmo_cnt <= '0;
         pat2_q <= 1'b0;
      end else if (state != ST_SEND) begin
         wid <= '0;
         tmo_cnt <= '0;
         pat2_q <= 1'b0;
      end else if (rx_edge) begin
         wid <= '0; // [RULE14]
         tmo_cnt <= '0;
         pat2_q <= hidx[0]; // [RULE2]
      end else begin
         wid <= (wid == '1) ? wid : wid + 1'b1; // [RULE14]
         tmo_cnt <= (rx_lvl || tmo_cnt == '1) ? (rx_lvl ? '0 : tmo_cnt) : tmo_cnt + 1'b1;
      end
   end

   // Sequencer: send, break, sample the bus, wait, resend
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         cur_frame <= '0;
         cur_prio <= '0;
         hidx <= '0;
         hc <= '0;
         tcnt <= '0;
         wtgt <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (q_valid) begin
                  cur_frame <= q_data[FRAME_W-1:0]; // [RULE13]
                  cur_prio <= q_data[QW-1:FRAME_W];
                  hidx <= '0;
                  hc <= '0;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (coll_hit) begin
                  tcnt <= '0;
                  state <= ST_BREAK; // [RULE7]
               end else if (half_tick) begin
                  hc <= '0;
                  hidx <= hidx + 1'b1;
                  if (hidx == LAST_HALF) begin
                     state <= ST_IDLE;
                  end
               end else begin
                  hc <= hc + 1'b1;
               end
            end
            ST_BREAK: begin
               tcnt <= tcnt + 1'b1;
               if (tcnt == BREAK_CYC - 1'b1) begin
                  tcnt <= '0;
                  state <= ST_SAMPLE; // [RULE8]
               end
            end
            ST_SAMPLE: begin
               // Gives the released line time to rise through the synchroniser
               tcnt <= tcnt + 1'b1;
               if (tcnt == C_SAMPLE - 1'b1) begin
                  tcnt <= '0;
                  wtgt <= rx_lvl ? RECOVER_CYC : settle(cur_prio); // [RULE9] [RULE10]
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               tcnt <= tcnt + 1'b1;
               if (retx_start) begin
                  hidx <= '0;
                  hc <= '0;
                  state <= ST_SEND; // [RULE7]
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Pin drive, status pulses and the sticky collision flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_pull_low <= 1'b0;
         tx_done <= 1'b0;
         xfer_abort <= 1'b0;
         coll_flag <= 1'b0;
         width_class <= WC_GREY;
      end else begin
         bus_pull_low <= (state == ST_BREAK) || // [RULE8]
            (state == ST_SEND && !coll_hit && !half_level(hidx, cur_frame)); // [RULE1]
         tx_done <= half_tick && (hidx == LAST_HALF) && !coll_hit;
         xfer_abort <= coll_hit; // [RULE7]
         if (coll_hit) begin
            coll_flag <= 1'b1; // [RULE15]
         end else if (retx_start) begin
            coll_flag <= 1'b0; // [RULE15]
         end
         if (state == ST_SEND && rx_edge) begin
            width_class <= wclass(wid, pat2_q);
         end
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   lbcr_cnt_t brk_run;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         brk_run <= '0;
      end else begin
         brk_run <= (state == ST_BREAK) ? brk_run + 1'b1 : '0;
      end
   end

   sequence retx_s;
      (state == ST_WAIT) ##1 (state == ST_SEND);
   endsequence

   sequence brk_hold_s;
      (state == ST_BREAK) ##1 (bus_pull_low && state == ST_BREAK)[*8];
   endsequence

   manch_flip_a: assert property ( // [RULE1]
      half_tick && !hidx[0] && hidx < DATA_HALVES && !coll_hit
      |-> ##2 (bus_pull_low != $past(bus_pull_low)))
      else $error("half-bits of one bit did not differ");
   pattern_pick_a: assert property ( // [RULE2]
      state == ST_SEND && rx_edge |=> pat2_q == $past(hidx[0]))
      else $error("wrong judgment pattern latched");
   destroy_hit_a: assert property ( // [RULE3]
      state == ST_SEND && mm_enable && rx_edge && wid >= DEST_LO && wid <= DEST1_HI
      |=> state == ST_BREAK)
      else $error("destroy width did not start a break");
   valid_half_a: assert property ( // [RULE3]
      state == ST_SEND && rx_edge && wid >= VALID_LO && wid <= VALID1_HI
      |-> !coll_hit ##1 width_class == WC_HALF)
      else $error("valid half bit misjudged");
   low_timeout_a: assert property ( // [RULE4]
      state == ST_SEND && mm_enable && !rx_lvl && !pat2_q && tmo_cnt >= TO1_CYC
      |=> state == ST_BREAK)
      else $error("low timeout missed");
   high_no_to_a: assert property ( // [RULE4]
      rx_lvl && !rx_edge |-> !coll_hit)
      else $error("high level raised a timeout");
   two_half_a: assert property ( // [RULE5]
      state == ST_SEND && rx_edge && pat2_q && wid >= VALID2_LO && wid <= VALID2_HI
      |=> width_class == WC_TWO)
      else $error("two half bits misjudged");
   no_check_a: assert property ( // [RULE6]
      (state != ST_SEND || !mm_enable) |-> !coll_hit)
      else $error("collision judged outside own frame or single-master");
   break_drive_a: assert property ( // [RULE8]
      coll_hit |=> brk_hold_s)
      else $error("bus not held low after collision");
   break_len_a: assert property ( // [RULE8]
      $fell(state == ST_BREAK) |-> brk_run == BREAK_CYC)
      else $error("break length wrong");
   recover_wait_a: assert property ( // [RULE9]
      state == ST_SAMPLE && tcnt == C_SAMPLE - 1'b1 && rx_lvl
      |=> state == ST_WAIT && wtgt == RECOVER_CYC)
      else $error("recovery wait not chosen");
   settle_wait_a: assert property ( // [RULE10]
      state == ST_SAMPLE && tcnt == C_SAMPLE - 1'b1 && !rx_lvl
      |=> state == ST_WAIT && wtgt == settle(cur_prio)) // [RULE11]
      else $error("settling wait not chosen");
   same_frame_a: assert property ( // [RULE7]
      retx_s |-> hidx == '0 && $stable(cur_frame) && !coll_flag) // [RULE15]
      else $error("resend changed frame or kept flag");
   flag_set_a: assert property ( // [RULE15]
      coll_hit |=> coll_flag && xfer_abort)
      else $error("collision flag not raised");
endmodule

// [bench/lbcr_bus_model.sv]
// Purpose: Shared bus wire with a second master that can pull it low on command.
// Assumes: Open-drain bus with a pull-up, so idle reads high.
// Notes: The other master only jams when told; it never drives high.
`timescale 1ns/1ps
module lbcr_bus_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Bus parties
   input wire logic dut_pull_low,
   input wire logic jam_go,
   input wire logic [15:0] jam_len,
   output logic bus_rx
);
   logic [15:0] left;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         left <= 16'h0000;
      end else if (jam_go) begin
         left <= jam_len;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
      end
   end

   // Wired level: any party pulling low wins over the pull-up
   assign bus_rx = !(dut_pull_low || (left != 16'h0000));
endmodule

// [bench/lbcr_top_tb_top.sv]
// Purpose: Self-checking bench for the collision recovery transmitter.
// Assumes: Timing windows scaled down so a full queue drains within the run.
// Notes: Inputs change at the falling edge; the jamming master sits in the bus model.
`timescale 1ns/1ps
module lbcr_top_tb_top;
   import lbcr_pkg::*;
   // Every window keeps its order relative to the half-bit length
   localparam lbcr_cnt_t HALF = 20'h00032;
   localparam lbcr_cnt_t DST_LO = 20'h0000C;
   localparam lbcr_cnt_t DST1_HI = 20'h0002A;
   localparam lbcr_cnt_t VAL_LO = 20'h00030;
   localparam lbcr_cnt_t VAL1_HI = 20'h00034;
   localparam lbcr_cnt_t TMO1 = 20'h00039;
   localparam lbcr_cnt_t DST2_HI = 20'h00056;
   localparam lbcr_cnt_t VAL2_LO = 20'h00060;
   localparam lbcr_cnt_t VAL2_HI = 20'h00068;
   localparam lbcr_cnt_t TMO2 = 20'h00071;
   localparam lbcr_cnt_t BRK = 20'h00096;
   localparam lbcr_cnt_t REC = 20'h001C2;
   localparam lbcr_cnt_t SET1 = 20'h005DC;
   localparam lbcr_cnt_t SET2 = 20'h00672;
   localparam lbcr_cnt_t SET3 = 20'h00708;
   localparam lbcr_cnt_t SET4 = 20'h007D0;
   localparam lbcr_cnt_t SET5 = 20'h00898;
   logic sys_clk, rst, mm_enable, frame_valid, frame_ready, bus_rx, bus_pull_low;
   logic busy, tx_done, coll_flag, xfer_abort, jam_go, ab, exp_lvl;
   logic [15:0] frame_data, jam_len;
   logic [2:0] frame_prio;
   lbcr_wclass_t width_class;
   int n_fail = 0;
   int checked = 0;
   int n, m;

   lbcr_top #(.HALF_CYC(HALF), .DEST_LO(DST_LO), .DEST1_HI(DST1_HI), .VALID_LO(VAL_LO),
      .VALID1_HI(VAL1_HI), .TO1_CYC(TMO1), .DEST2_HI(DST2_HI), .VALID2_LO(VAL2_LO),
      .VALID2_HI(VAL2_HI), .TO2_CYC(TMO2), .BREAK_CYC(BRK), .RECOVER_CYC(REC),
      .SETTLE1_CYC(SET1), .SETTLE2_CYC(SET2), .SETTLE3_CYC(SET3), .SETTLE4_CYC(SET4),
      .SETTLE5_CYC(SET5)) u_lbcr_top (
      .sys_clk(sys_clk), .rst(rst), .mm_enable(mm_enable), .frame_valid(frame_valid),
      .frame_ready(frame_ready), .frame_data(frame_data), .frame_prio(frame_prio),
      .bus_rx(bus_rx), .bus_pull_low(bus_pull_low), .busy(busy), .tx_done(tx_done),
      .coll_flag(coll_flag), .xfer_abort(xfer_abort), .width_class(width_class));

   lbcr_bus_model u_lbcr_bus_model (.sys_clk(sys_clk), .rst(rst), .dut_pull_low(bus_pull_low),
      .jam_go(jam_go), .jam_len(jam_len), .bus_rx(bus_rx));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Expected settling wait per priority; anything outside one to five waits longest
   function automatic int settle_exp(input int p);
      case (p)
         1: return SET1;
         2: return SET2;
         3: return SET3;
         4: return SET4;
         default: return SET5;
      endcase
   endfunction

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic push(input logic [15:0] d, input logic [2:0] p);
      frame_data = d;
      frame_prio = p;
      frame_valid = 1'b1;
      @(negedge sys_clk);
      frame_valid = 1'b0;
   endtask

   task automatic wpull(input logic v, input int lim);
      n = 0;
      while (bus_pull_low !== v && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      chk("bus pull wait", n < lim, 1'b1);
   endtask

   task automatic wdone(input int lim);
      ab = 1'b0;
      m = 0;
      while (tx_done !== 1'b1 && m < lim) begin
         @(negedge sys_clk);
         m++;
         ab = ab | (xfer_abort === 1'b1);
      end
      chk("frame done wait", m < lim, 1'b1);
      @(negedge sys_clk);
   endtask

   // Other master pulls low some cycles after this end starts its frame
   task automatic jam(input int at, input logic [15:0] len);
      wpull(1'b1, 10);
      repeat (at) @(negedge sys_clk);
      jam_len = len;
      jam_go = 1'b1;
      @(negedge sys_clk);
      jam_go = 1'b0;
   endtask

   task automatic wabort(input int lim);
      m = 0;
      while (xfer_abort !== 1'b1 && m < lim) begin
         @(negedge sys_clk);
         m++;
      end
      chk("abort seen", m < lim, 1'b1);
      chk("collision flag set", coll_flag, 1'b1);
   endtask

   // Break length, then gap from release to resend start
   task automatic recover(input int wait_cyc);
      wpull(1'b1, 10);
      wpull(1'b0, 400);
      chk("break length", n >= BRK - 1 && n <= BRK + 1, 1'b1);
      wpull(1'b1, 3000);
      chk("resend gap", n >= wait_cyc + 6 && n <= wait_cyc + 14, 1'b1);
      chk("flag cleared at resend", coll_flag, 1'b0);
      wdone(2100);
      chk("resend not aborted", ab, 1'b0);
   endtask

   task automatic t_clean;
      push(16'hA5C3, 3'h1);
      wpull(1'b1, 10);
      repeat (HALF / 2) @(negedge sys_clk);
      for (int h = 0; h < 34; h++) begin
         exp_lvl = (h < 2) ? 1'b1 : frame_data[16 - h / 2];
         chk("half level", bus_pull_low, (h % 2 == 0) ? exp_lvl : !exp_lvl);
         chk("no destroy", width_class != WC_DESTROY, 1'b1);
         repeat (HALF) @(negedge sys_clk);
      end
      wdone(300);
      chk("clean abort", ab, 1'b0);
      chk("clean flag", coll_flag, 1'b0);
      chk("idle after frame", busy, 1'b0);
   endtask

   task automatic t_resolved;
      push(16'h1234, 3'h2);
      jam(HALF + 10, 16'h0019);
      wabort(80);
      chk("destroy class", width_class, WC_DESTROY);
      recover(REC);
   endtask

   task automatic t_continue(input int p);
      push(16'h00FF, 3'(p));
      // Odd: jam cuts a mid-bit high level; even: jam stretches the start-bit low half
      jam((p % 2 == 1) ? HALF + 10 : HALF / 2, 16'h0190);
      wabort(200);
      recover(settle_exp(p));
   endtask

   task automatic t_single;
      mm_enable = 1'b0;
      push(16'h5A5A, 3'h1);
      jam(HALF + 10, 16'h0019);
      wdone(2500);
      chk("no abort single master", ab, 1'b0);
      chk("no flag single master", coll_flag, 1'b0);
      mm_enable = 1'b1;
   endtask

   task automatic t_fifo;
      n = 0;
      while (frame_ready === 1'b1 && n < 40) begin
         frame_data = 16'(n);
         frame_valid = 1'b1;
         @(negedge sys_clk);
         n++;
      end
      chk("frames accepted", n, 17);
      // Full queue must refuse this extra frame
      push(16'hFFFF, 3'h1);
      for (int i = 0; i < 17; i++) begin
         wdone(2100);
      end
      repeat (100) @(negedge sys_clk);
      chk("drained and idle", busy, 1'b0);
      chk("room again", frame_ready, 1'b1);
   endtask

   initial begin
      repeat (80000) @(posedge sys_clk);
      n_fail++;
      end_of_test();
   end

   initial begin
      rst = 1'b1;
      mm_enable = 1'b1;
      frame_valid = 1'b0;
      frame_data = 16'h0000;
      frame_prio = 3'h1;
      jam_go = 1'b0;
      jam_len = 16'h0000;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_clean();
      t_resolved();
      for (int p = 1; p <= 5; p++) begin
         t_continue(p);
      end
      t_single();
      t_fifo();
      end_of_test();
   end
endmodule
